// >>> common/tmr16_pkg.sv
// package for the 16-bit interval/capture/pwm timer: register map, control
// field layout, reset values and encodings.
// assumes an apb slave with 32-bit data, one register per aligned word.
package tmr16_pkg;

  // register byte offsets
  localparam logic [7:0] TMR16_OFF_CTRL = 8'h40;
  localparam logic [7:0] TMR16_OFF_CNT = 8'h44;
  localparam logic [7:0] TMR16_OFF_REF = 8'h48;
  localparam logic [7:0] TMR16_OFF_STAT = 8'h4c;
  localparam logic [7:0] TMR16_OFF_MASK = 8'h50;
  localparam logic [7:0] TMR16_OFF_PORT7 = 8'h54;

  // reset values
  localparam logic [7:0] TMR16_CTRL_RST = 8'h00;
  localparam logic [7:0] TMR16_PORT7_RST = 8'h00;
  localparam logic [15:0] TMR16_REF_RST = 16'hffff;

  // control field positions
  localparam int TMR16_CLK_HI = 7;
  localparam int TMR16_CLK_LO = 5;
  localparam int TMR16_MODE_HI = 4;
  localparam int TMR16_MODE_LO = 3;
  localparam int TMR16_CLR_BIT = 2;
  localparam int TMR16_EDGE_BIT = 1;

  // port 7 capture-pin function field
  localparam int TMR16_P7_HI = 7;
  localparam int TMR16_P7_LO = 6;
  localparam logic [1:0] TMR16_P7_CAPIN = 2'h0;
  localparam logic [1:0] TMR16_P7_OUT = 2'h3;

  // status bit positions
  localparam int TMR16_ST_MATCH = 0;
  localparam int TMR16_ST_OVF = 1;

  // count clock selections
  localparam logic [2:0] TMR16_CK_1024 = 3'h0;
  localparam logic [2:0] TMR16_CK_256 = 3'h1;
  localparam logic [2:0] TMR16_CK_64 = 3'h2;
  localparam logic [2:0] TMR16_CK_8 = 3'h3;
  localparam logic [2:0] TMR16_CK_1 = 3'h4;
  localparam logic [2:0] TMR16_CK_EXT = 3'h5;
  localparam logic [2:0] TMR16_CK_STOP = 3'h7;

  localparam int TMR16_PRE_W = 10;

  typedef enum logic [1:0] {
    TMR16_INTERVAL = 2'h0,
    TMR16_CAPTURE = 2'h1,
    TMR16_PWM = 2'h3
  } tmr16_mode_t;

endpackage : tmr16_pkg

// >>> hw/tmr16_timer.sv
// 16-bit timer/counter with interval, capture and pwm modes behind apb.
// assumes pins external_count_clock and capture_in are asynchronous; all
// logic runs on mclk.
`timescale 1ns/10ps

// Summary of operation
// - three modes chosen by control field
// - count clock from prescaler taps or pin
// - 16-bit counter, comparator, reference; bytes readable
// - overflow and match/capture interrupts separate
// - interval match toggles output pin
// - interval match interrupts and clears counter
// - pwm match keeps counting, may interrupt
// - pwm counter wraps, wrap may interrupt
// - pwm low when reference <= counter
// - capture edge copies counter into reference
// - capture edge rising or falling selectable
// - port7 bits 7:6 choose capture pin function
// - capture mode overflow and load interrupts
// - control register at 40h, mode/clock/clear
// - reset loads control with 00h
// - clock field 111b stops counting
// - writing one to bit 2 clears counter
module tmr16_timer
  import tmr16_pkg::*;
#(
  // counter and prescaler widths
  parameter int CNT_W = 16,
  parameter int PRE_W = TMR16_PRE_W
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic external_count_clock,
  input wire logic capture_in,
  output logic match_toggle_out,
  output logic pwm_out,
  output logic capture_pin_out_en,
  // interrupts
  output logic overflow_irq,
  output logic match_capture_irq,
  output logic irq
);

  // the register views below are laid out for a 16-bit count, and the
  // slowest prescaler tap needs ten bits of prescaler
  if (CNT_W != 16)
  begin : g_bad_cnt_w
    $error("counter width must be 16");
  end
  if (PRE_W < 10)
  begin : g_bad_pre_w
    $error("prescaler too narrow for the slowest tap");
  end

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] port7;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] refv;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [PRE_W-1:0] pre;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] prev;
    logic toggle;
    logic pwm;
    logic [31:0] rdata;
  } tmr16_state_t;

  // positions of the two pins inside the synchroniser vectors
  localparam int PIN_EXT = 0;
  localparam int PIN_CAP = 1;

  tmr16_state_t st_r;
  tmr16_state_t st_nxt;

  logic wr_en;
  logic rd_en;
  logic mapped;
  logic acc;
  logic tick;
  logic match;
  logic wrap;
  logic cap_edge;
  logic cap_sel;
  logic clears_on_match;
  logic [1:0] ev;
  logic [1:0] pin_in;
  logic [1:0] pin_rise;
  logic [1:0] pin_fall;
  logic [1:0] irq_src;
  logic [1:0] p7_func;
  tmr16_mode_t mode;
  logic [2:0] cksel;

  // decode used by read and write paths
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == TMR16_OFF_CTRL) || (a == TMR16_OFF_CNT) ||
                (a == TMR16_OFF_REF) || (a == TMR16_OFF_STAT) ||
                (a == TMR16_OFF_MASK) || (a == TMR16_OFF_PORT7);
  endfunction : is_mapped

  // the prescaler tap for a selection; taps fire on the wrap of low bits
  function automatic logic tap_hit(input logic [2:0] s,
                                   input logic [PRE_W-1:0] p);
    case (s)
      TMR16_CK_1024:
        tap_hit = (p[9:0] == 10'h3ff);
      TMR16_CK_256:
        tap_hit = (p[7:0] == 8'hff);
      TMR16_CK_64:
        tap_hit = (p[5:0] == 6'h3f);
      TMR16_CK_8:
        tap_hit = (p[2:0] == 3'h7);
      TMR16_CK_1:
        tap_hit = 1'b1;
      default:
        tap_hit = 1'b0;
    endcase
  endfunction : tap_hit

  // every 16-bit view sits in the low half of one word
  function automatic logic [31:0] read_word(input logic [7:0] a,
                                            input tmr16_state_t s);
    logic [31:0] w;
    w = 32'h00000000;
    case (a)
      TMR16_OFF_CTRL:
        w[7:0] = s.ctrl;
      TMR16_OFF_CNT:
        w[CNT_W-1:0] = s.cnt;
      TMR16_OFF_REF:
        w[CNT_W-1:0] = s.refv;
      TMR16_OFF_STAT:
        w[1:0] = s.stat;
      TMR16_OFF_MASK:
        w[1:0] = s.mask;
      TMR16_OFF_PORT7:
        w[7:0] = s.port7;
      default:
        w = 32'h00000000;
    endcase
    read_word = w;
  endfunction : read_word

  // apb decode; zero-wait slave, unmapped addresses answer with pslverr
  assign mapped = is_mapped(paddr);
  assign acc = psel && penable;
  assign wr_en = acc && pwrite && mapped;
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata = st_r.rdata;

  // both pins pass two flops; the second flop and its one-cycle delayed copy feed the edge logic
  assign pin_in[PIN_EXT] = external_count_clock;
  assign pin_in[PIN_CAP] = capture_in;
  for (genvar i = 0; i < 2; i++)
  begin : g_pin_edge
    assign pin_rise[i] = st_r.sync2[i] && !st_r.prev[i];
    assign pin_fall[i] = !st_r.sync2[i] && st_r.prev[i];
  end

  // control field decode
  always_comb
  begin
    mode = tmr16_mode_t'(st_r.ctrl[TMR16_MODE_HI:TMR16_MODE_LO]);
    cksel = st_r.ctrl[TMR16_CLK_HI:TMR16_CLK_LO];
    p7_func = st_r.port7[TMR16_P7_HI:TMR16_P7_LO];
    clears_on_match = (mode == TMR16_INTERVAL);
  end

  // count tick selection
  always_comb
  begin
    // divided system clock or synchronised pin rising edge
    if (cksel == TMR16_CK_EXT)
    begin
      tick = pin_rise[PIN_EXT];
    end
    else
    begin
      tick = tap_hit(cksel, st_r.pre);  // stop code gives no tick
    end
  end

  // compare and wrap detection
  always_comb
  begin
    match = (st_r.cnt == st_r.refv) && tick && (mode != TMR16_CAPTURE);
    wrap = tick && (st_r.cnt == {CNT_W{1'b1}});
  end

  // capture edge: the pin must be handed to the timer by port 7
  always_comb
  begin
    cap_sel = (mode == TMR16_CAPTURE) && (p7_func == TMR16_P7_CAPIN);
    // edge select: 0 rising, 1 falling
    if (st_r.ctrl[TMR16_EDGE_BIT])
    begin
      cap_edge = cap_sel && pin_fall[PIN_CAP];
    end
    else
    begin
      cap_edge = cap_sel && pin_rise[PIN_CAP];
    end
  end

  // event bits: match/capture 0, overflow 1
  always_comb
  begin
    ev = 2'h0;
    ev[TMR16_ST_MATCH] = match || cap_edge;
    ev[TMR16_ST_OVF] = wrap;
  end

  always_comb
  begin
    st_nxt = st_r;

    // synchronisers and free-running prescaler
    st_nxt.sync1 = pin_in;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev = st_r.sync2;
    st_nxt.pre = st_r.pre + {{(PRE_W-1){1'b0}}, 1'b1};

    // counter
    if (tick)
    begin
      if (match && clears_on_match)
      begin
        st_nxt.cnt = '0;
      end
      else
      begin
        st_nxt.cnt = st_r.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end

    // match toggle output
    if (match && clears_on_match)
    begin
      st_nxt.toggle = !st_r.toggle;
    end

    // registered compare, one cycle behind the counter
    st_nxt.pwm = (mode == TMR16_PWM) && (st_r.refv > st_r.cnt);

    // capture load
    if (cap_edge)
    begin
      st_nxt.refv = st_r.cnt;
    end

    // register writes
    if (wr_en)
    begin
      case (paddr)
        TMR16_OFF_CTRL:
        begin
          // clear bit acts, then reads back zero
          st_nxt.ctrl = pwdata[7:0] & ~(8'h01 << TMR16_CLR_BIT);
          if (pwdata[TMR16_CLR_BIT])
          begin
            st_nxt.cnt = '0;
          end
        end
        TMR16_OFF_REF:
        begin
          // a capture owns the reference; software may not overwrite it
          if (mode != TMR16_CAPTURE)
          begin
            st_nxt.refv = pwdata[CNT_W-1:0];
          end
        end
        TMR16_OFF_STAT:
        begin
          st_nxt.stat = st_r.stat & ~pwdata[1:0];
        end
        TMR16_OFF_MASK:
        begin
          st_nxt.mask = pwdata[1:0];
        end
        TMR16_OFF_PORT7:
        begin
          st_nxt.port7 = pwdata[7:0];
        end
        default:
        begin
          st_nxt.stat = st_r.stat;
        end
      endcase
    end

    // hardware set wins over a write-one clear in the same cycle
    st_nxt.stat = st_nxt.stat | ev;

    // read data latched in setup for the access phase
    if (rd_en)
    begin
      st_nxt.rdata = read_word(paddr, st_r);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      st_r <= '0;
      st_r.ctrl <= TMR16_CTRL_RST;
      st_r.port7 <= TMR16_PORT7_RST;
      st_r.refv <= TMR16_REF_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // pin outputs
  assign match_toggle_out = st_r.toggle;
  assign pwm_out = st_r.pwm;
  // 11 hands the capture pin to the port as a plain output
  assign capture_pin_out_en = (p7_func == TMR16_P7_OUT);

  // one level request per source, gated by its mask bit
  for (genvar j = 0; j < 2; j++)
  begin : g_irq
    assign irq_src[j] = st_r.stat[j] && st_r.mask[j];
  end
  assign match_capture_irq = irq_src[TMR16_ST_MATCH];
  assign overflow_irq = irq_src[TMR16_ST_OVF];
  assign irq = match_capture_irq || overflow_irq;

endmodule : tmr16_timer

// >>> verif/tmr16_checker.sv
// assertions on the timer's apb, pin-enable and interrupt ports.
// assumes a single mclk domain with synchronous active-high reset.
`timescale 1ns/10ps
module tmr16_checker
  import tmr16_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // pin enable and interrupts
  input wire logic capture_pin_out_en,
  input wire logic overflow_irq,
  input wire logic match_capture_irq,
  input wire logic irq
);
  logic acc;
  logic map;
  assign acc = psel && penable;
  assign map = paddr inside {TMR16_OFF_CTRL, TMR16_OFF_CNT, TMR16_OFF_REF,
    TMR16_OFF_STAT, TMR16_OFF_MASK, TMR16_OFF_PORT7};
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  a_irq_is_or:
    assert property (irq == (overflow_irq | match_capture_irq))
    else $error("irq not or of sources");
  a_unmapped_err:
    assert property (acc && !map |-> pslverr) else $error("no slverr");
  a_mapped_ok:
    assert property (acc && map |-> !pslverr) else $error("bad slverr");
  a_oe_on:
    assert property (acc && pwrite && paddr == TMR16_OFF_PORT7 &&
      pwdata[7:6] == 2'h3 |=> capture_pin_out_en) else $error("oe off");
  a_oe_off:
    assert property (acc && pwrite && paddr == TMR16_OFF_PORT7 &&
      pwdata[7:6] != 2'h3 |=> !capture_pin_out_en) else $error("oe on");
  a_mask_off:
    assert property (acc && pwrite && paddr == TMR16_OFF_MASK &&
      pwdata[1:0] == 2'h0 |=> !irq) else $error("masked irq high");
  a_ovf_masked:
    assert property (acc && pwrite && paddr == TMR16_OFF_MASK &&
      !pwdata[1] |=> !overflow_irq [*2]) else $error("masked ovf high");
  a_reset_quiet:
    assert property ($fell(reset) |-> !irq) else $error("irq after reset");
  a_clr_reads0:
    assert property (acc && !pwrite && paddr == TMR16_OFF_CTRL |->
      !prdata[TMR16_CLR_BIT]) else $error("clear bit reads one");
  c_oe: cover property (capture_pin_out_en);
  c_ovf: cover property ($rose(overflow_irq));
  c_mc: cover property ($rose(match_capture_irq));
endmodule : tmr16_checker

bind tmr16_timer tmr16_checker u_chk (.mclk, .reset, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pslverr, .capture_pin_out_en,
  .overflow_irq, .match_capture_irq, .irq);

// >>> verif/tmr16_pins.sv
// model of the far-side pins: external count clock and capture input.
// assumes the timer synchronizes both pins to mclk.
`timescale 1ns/10ps
module tmr16_pins (
  // clock
  input wire logic mclk,
  // pins
  output logic external_count_clock,
  output logic capture_in
);
  initial
  begin
    external_count_clock = 1'b0;
    capture_in = 1'b0;
  end
  // at least three cycles each level so the two-flop synchronizer never drops one
  task tick(input int n);
    repeat (n)
    begin
      @(posedge mclk) external_count_clock <= 1'b1;
      repeat (3) @(posedge mclk);
      external_count_clock <= 1'b0;
      repeat (3) @(posedge mclk);
    end
  endtask : tick
  task drive_cap(input logic v);
    @(posedge mclk) capture_in <= v;
    repeat (6) @(posedge mclk);
  endtask : drive_cap
endmodule : tmr16_pins

// >>> verif/tb_top.sv
// self-checking bench for the timer: apb master, pin model, scenarios.
// assumes the checker is bound from its own file.
`timescale 1ns/10ps
module tb_top;
  logic mclk, reset, psel, penable, pwrite, pready, pslverr, serr, tog;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic external_count_clock, capture_in, match_toggle_out, pwm_out;
  logic capture_pin_out_en, overflow_irq, match_capture_irq, irq;
  int fail_count, n_tests, c;
  int div [5] = '{1024, 256, 64, 8, 1};
  tmr16_timer dut (.mclk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .external_count_clock,
    .capture_in, .match_toggle_out, .pwm_out, .capture_pin_out_en,
    .overflow_irq, .match_capture_irq, .irq);
  tmr16_pins pins (.mclk, .external_count_clock, .capture_in);
  always #10 mclk = ~mclk;
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk) penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rdata = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      fail_count++;
      $display("ERROR %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task tally_and_finish;
    if (fail_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  task t_reset;
    apb(0, 8'h40, 0); chk(rdata, 0);
    apb(0, 8'h48, 0); chk(rdata, 32'hffff);
    apb(0, 8'h5c, 0); chk({serr, rdata[30:0]}, 32'h80000000);
  endtask : t_reset
  task t_count;
    apb(1, 8'h40, 32'ha4); pins.tick(5);
    apb(0, 8'h44, 0); chk(rdata, 5);
    apb(1, 8'h40, 32'ha4); apb(0, 8'h44, 0); chk(rdata, 0);
    apb(0, 8'h40, 0); chk(rdata, 32'ha0);
    apb(1, 8'h40, 32'he0); pins.tick(3);
    apb(0, 8'h44, 0); chk(rdata, 0);
  endtask : t_count
  task t_interval;
    apb(1, 8'h48, 3); apb(1, 8'h50, 1); apb(1, 8'h4c, 3);
    apb(1, 8'h40, 32'ha4); tog = match_toggle_out; pins.tick(4);
    apb(0, 8'h44, 0); chk(rdata, 0);
    chk(match_toggle_out, !tog);
    chk(irq, 1);
    pins.tick(1); apb(0, 8'h44, 0); chk(rdata, 1);
    apb(1, 8'h50, 0); @(negedge mclk); chk(irq, 0);
    apb(1, 8'h4c, 1); apb(0, 8'h4c, 0); chk(rdata, 0);
  endtask : t_interval
  task t_pwm;
    apb(1, 8'h48, 2); apb(1, 8'h40, 32'hbc);
    repeat (3) @(negedge mclk); chk(pwm_out, 1);
    pins.tick(2); chk(pwm_out, 0);
    pins.tick(1); apb(0, 8'h44, 0); chk(rdata, 3);
    apb(0, 8'h4c, 0); chk(rdata[0], 1);
    apb(1, 8'h50, 2); apb(1, 8'h40, 32'h9c); c = 0;
    while (overflow_irq !== 1'b1 && c < 70000)
    begin
      @(posedge mclk);
      c++;
    end
    chk(c > 65000, 1);
    apb(0, 8'h44, 0); chk(rdata < 16, 1);
    apb(1, 8'h4c, 3); apb(1, 8'h48, 32'hffff);
  endtask : t_pwm
  task t_prescale;
    for (int k = 0; k < 5; k++)
    begin
      apb(1, 8'h40, {k[2:0], 5'h04});
      repeat (8 * div[k]) @(posedge mclk);
      apb(0, 8'h44, 0); chk(rdata inside {[7:11]}, 1);
    end
  endtask : t_prescale
  task t_capture;
    apb(1, 8'h50, 1); apb(1, 8'h40, 32'hac); apb(1, 8'h4c, 3);
    pins.tick(7); pins.drive_cap(1);
    apb(0, 8'h48, 0); chk(rdata, 7);
    chk(match_capture_irq, 1);
    apb(1, 8'h40, 32'haa); pins.tick(2); pins.drive_cap(0);
    apb(0, 8'h48, 0); chk(rdata, 9);
    apb(1, 8'h54, 32'hc0); @(negedge mclk); chk(capture_pin_out_en, 1);
    apb(1, 8'h54, 0); @(negedge mclk); chk(capture_pin_out_en, 0);
  endtask : t_capture
  initial
  begin
    mclk = 1'b0;
    reset = 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h00000000;
    fail_count = 0;
    n_tests = 0;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    t_reset;
    t_count;
    t_interval;
    t_pwm;
    t_prescale;
    t_capture;
    tally_and_finish;
  end
  // the overflow wait alone is some 65k cycles and the run about 77k
  initial
  begin
    #1800000;
    fail_count++;
    tally_and_finish;
  end
endmodule : tb_top
